/* File: rtl/ctio_pkg.sv */
package ctio_pkg;

  localparam int ADDR_W  = 5;
  localparam int DATA_W  = 8;
  localparam int NUM_OPT = 4;

  // Register offsets
  localparam logic [4:0] OFF_CTRL        = 5'h00;
  localparam logic [4:0] OFF_BUFFER_OPT  = 5'h0d;
  localparam logic [4:0] OFF_CACHE_BEHAV = 5'h0e;
  localparam logic [4:0] OFF_RATE_COMPAT = 5'h0f;
  localparam logic [4:0] OFF_GENERAL_A   = 5'h10;
  localparam logic [4:0] OFF_READAHEAD   = 5'h11;
  localparam logic [4:0] OFF_GENERAL_B   = 5'h12;

  // Storage index of each option byte
  localparam logic [1:0] IDX_BUFFER = 2'h0;
  localparam logic [1:0] IDX_CACHE  = 2'h1;
  localparam logic [1:0] IDX_RATE   = 2'h2;
  localparam logic [1:0] IDX_STOP   = 2'h3;
  localparam logic [4:0] OPT_ADDR [0:3] = '{OFF_BUFFER_OPT, OFF_CACHE_BEHAV,
                                            OFF_RATE_COMPAT, OFF_READAHEAD};

  // Field positions
  localparam int BUF_SEL_BIT     = 6;
  localparam int BUF_FROM_NV_BIT = 4;
  localparam int LOW_RATE_BIT    = 7;
  localparam int GO_BUSY_BIT     = 6;
  localparam int PARITY_OFF_BIT  = 5;
  localparam int EOT_MARK_BIT    = 4;
  localparam int RETRY_LSB       = 2;
  localparam int CACHE_LSB       = 0;
  localparam int COMPAT_LSB      = 5;
  localparam int RAMP_LSB        = 3;
  localparam int RATE_LSB        = 0;
  localparam int MARKS_LSB       = 0;
  localparam int CTRL_RELOAD_BIT = 0;
  localparam int CTRL_EARLY_BIT  = 1;
  localparam int STAT_BUSY_BIT   = 2;

  // Reset values, and the count that a zero marks code decodes to
  localparam logic [7:0] OPT_RESET   = 8'h00;
  localparam logic [7:0] MARKS_ZERO  = 8'hff;
  localparam logic       EARLY_RESET = 1'b0;

  typedef enum logic [1:0] {
    CACHE_NORMAL = 2'h0,
    CACHE_OFF    = 2'h1,
    CACHE_RSVD   = 2'h2,
    CACHE_LONG   = 2'h3
  } ctio_cache_mode_e;

  typedef enum logic [3:0] {
    LD_IDLE = 4'b0001,
    LD_READ = 4'b0010,
    LD_WAIT = 4'b0100,
    LD_CAPT = 4'b1000
  } ctio_load_state_e;

  // Retry budgets, ramp delays in ms, host rates in kB/s
  localparam logic [5:0]  RETRY_WR [0:3] = '{6'h00, 6'h10, 6'h20, 6'h30};
  localparam logic [3:0]  RETRY_RD [0:3] = '{4'h4, 4'h4, 4'h8, 4'hc};
  localparam logic [3:0]  RAMP_RD  [0:3] = '{4'h0, 4'h2, 4'h4, 4'h8};
  localparam logic [6:0]  RAMP_WR  [0:3] = '{7'h00, 7'h02, 7'h04, 7'h78};
  localparam logic [10:0] RATE_LO  [0:7] = '{11'h00a, 11'h01e, 11'h032, 11'h048,
                                             11'h064, 11'h078, 11'h09c, 11'h0c1};
  localparam logic [10:0] RATE_HI  [0:7] = '{11'h116, 11'h138, 11'h165, 11'h1a0,
                                             11'h1f4, 11'h271, 11'h341, 11'h4e2};

endpackage

/* File: rtl/ctio_rate_lut.sv */
`timescale 1ns/100ps
`default_nettype none

// Pure lookup; the caller registers the result
module ctio_rate_lut (
  input  wire logic [2:0]  rate_sel_in,
  input  wire logic        low_set_in,
  input  wire logic [1:0]  ramp_sel_in,
  output logic      [10:0] rate_kbps_out,
  output logic      [3:0]  ramp_rd_ms_out,
  output logic      [6:0]  ramp_wr_ms_out
);

  assign rate_kbps_out  = low_set_in ? ctio_pkg::RATE_LO[rate_sel_in]
                                     : ctio_pkg::RATE_HI[rate_sel_in];
  assign ramp_rd_ms_out = ctio_pkg::RAMP_RD[ramp_sel_in];
  assign ramp_wr_ms_out = ctio_pkg::RAMP_WR[ramp_sel_in];

endmodule

`default_nettype wire

/* File: rtl/ctio_nvs_loader.sv */
`timescale 1ns/100ps
`default_nettype none

module ctio_nvs_loader #(
  parameter int NUM_ENTRIES = 4
) (
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       start_in,
  output logic            rd_out,
  output logic      [4:0] addr_out,
  output logic            we_out,
  output logic      [1:0] idx_out,
  output logic            busy_out
);

  if (NUM_ENTRIES < 1 || NUM_ENTRIES > 4) begin : g_check
    $error("ctio_nvs_loader: NUM_ENTRIES must be 1 to 4");
  end

  ctio_pkg::ctio_load_state_e state_reg;
  logic [1:0]                 idx_reg;
  logic                       rd_reg;
  logic [4:0]                 addr_reg;
  wire                        last_w = (idx_reg == 2'(NUM_ENTRIES - 1));

  // Starts in READ so the store is fetched right after reset
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg <= ctio_pkg::LD_READ;
      idx_reg   <= 2'h0;
      rd_reg    <= 1'b0;
      addr_reg  <= 5'h00;
    end else begin
      case (state_reg)
        ctio_pkg::LD_IDLE: begin
          idx_reg <= 2'h0;
          if (start_in) begin
            state_reg <= ctio_pkg::LD_READ;
          end
        end
        ctio_pkg::LD_READ: begin
          rd_reg    <= 1'b1;
          addr_reg  <= ctio_pkg::OPT_ADDR[idx_reg];
          state_reg <= ctio_pkg::LD_WAIT;
        end
        ctio_pkg::LD_WAIT: begin
          rd_reg    <= 1'b0;
          state_reg <= ctio_pkg::LD_CAPT;
        end
        ctio_pkg::LD_CAPT: begin
          idx_reg   <= last_w ? 2'h0 : idx_reg + 2'h1;
          state_reg <= last_w ? ctio_pkg::LD_IDLE : ctio_pkg::LD_READ;
        end
        default: begin
          state_reg <= ctio_pkg::LD_IDLE;
        end
      endcase
    end
  end

  assign rd_out   = rd_reg;
  assign addr_out = addr_reg;
  assign we_out   = (state_reg == ctio_pkg::LD_CAPT);
  assign idx_out  = idx_reg;
  assign busy_out = (state_reg != ctio_pkg::LD_IDLE);

endmodule

`default_nettype wire

/* File: rtl/ctio_option_decoder.sv */
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Stored one means switch on, no inversion
// - Byte 13: bit6 buffered select, bit4 source
// - Byte 14: rates, go, parity, eot, retries, cache
// - Cache mode: normal, off, reserved, long-block
// - Byte 15: ramp delay and host rate
// - Early layout: 2-bit compat in bits 6-5
// - Later layout: 3-bit compat in bits 7-5
// - Byte 17 marks count, zero means 255
// - Early layout: bit6 means configured, bit7 unused; the configured output follows the layout flag, and bit6 stays buffered select
// - Bytes 16 and 18 are not decoded here
module ctio_option_decoder (
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic [4:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  input  wire logic [7:0] nvs_rdata_in,
  output logic            nvs_rd_out,
  output logic      [4:0] nvs_raddr_out,
  output logic            nvs_wr_out,
  output logic      [4:0] nvs_waddr_out,
  output logic      [7:0] nvs_wdata_out,
  output logic            buffered_host_port_out,
  output logic            buffered_configured_out,
  output logic            buffered_from_store_out,
  output logic            low_rate_set_out,
  output logic            go_sets_interface_busy_out,
  output logic            parity_check_off_out,
  output logic            end_of_tape_indication_out,
  output logic      [5:0] write_retries_out,
  output logic      [3:0] read_retries_out,
  output logic      [1:0] cache_mode_out,
  output logic            cache_enabled_out,
  output logic            cache_long_block_out,
  output logic            cache_mode_reserved_out,
  output logic      [3:0] ramp_read_ms_out,
  output logic      [6:0] ramp_write_ms_out,
  output logic     [10:0] host_rate_kbps_out,
  output logic      [2:0] compat_code_out,
  output logic      [7:0] stop_marks_out
);

  logic [7:0]  opt_reg [0:3];
  logic        early_reg;
  logic [7:0]  rdata_reg;
  logic        nvs_wr_reg;
  logic [4:0]  nvs_waddr_reg;
  logic [7:0]  nvs_wdata_reg;

  logic        ld_we;
  logic [1:0]  ld_idx;
  logic        ld_busy;
  logic [10:0] lut_rate;
  logic [3:0]  lut_ramp_rd;
  logic [6:0]  lut_ramp_wr;

  // Address decode
  wire is_ctrl  = (reg_addr_in == ctio_pkg::OFF_CTRL);
  wire is_buf   = (reg_addr_in == ctio_pkg::OFF_BUFFER_OPT);
  wire is_cache = (reg_addr_in == ctio_pkg::OFF_CACHE_BEHAV);
  wire is_rate  = (reg_addr_in == ctio_pkg::OFF_RATE_COMPAT);
  wire is_stop  = (reg_addr_in == ctio_pkg::OFF_READAHEAD);
  wire is_opt   = is_buf | is_cache | is_rate | is_stop;
  wire reload   = reg_wr_in & is_ctrl & reg_wdata_in[ctio_pkg::CTRL_RELOAD_BIT];

  wire [7:0] b13 = opt_reg[ctio_pkg::IDX_BUFFER];
  wire [7:0] b14 = opt_reg[ctio_pkg::IDX_CACHE];
  wire [7:0] b15 = opt_reg[ctio_pkg::IDX_RATE];
  wire [7:0] b17 = opt_reg[ctio_pkg::IDX_STOP];

  wire [7:0] status_w = {5'h00, ld_busy, early_reg, 1'b0};
  // Bytes 16, 18 and unmapped offsets read zero
  wire [7:0] rd_mux = is_ctrl  ? status_w :
                      is_buf   ? b13 :
                      is_cache ? b14 :
                      is_rate  ? b15 :
                      is_stop  ? b17 : 8'h00;

  wire [1:0] cache_w  = b14[ctio_pkg::CACHE_LSB +: 2];
  wire [1:0] retry_w  = b14[ctio_pkg::RETRY_LSB +: 2];
  wire [3:0] marks_w  = b17[ctio_pkg::MARKS_LSB +: 4];
  // Early layout leaves bit 7 out of the code
  wire [2:0] compat_w = early_reg ? {1'b0, b15[ctio_pkg::COMPAT_LSB +: 2]}
                                  : b15[ctio_pkg::COMPAT_LSB +: 3];
  wire [7:0] marks_count_w = (marks_w == 4'h0) ? ctio_pkg::MARKS_ZERO
                                               : {4'h0, marks_w};

  ctio_nvs_loader #(
    .NUM_ENTRIES (ctio_pkg::NUM_OPT)
  ) u_loader (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .start_in   (reload),
    .rd_out     (nvs_rd_out),
    .addr_out   (nvs_raddr_out),
    .we_out     (ld_we),
    .idx_out    (ld_idx),
    .busy_out   (ld_busy)
  );

  ctio_rate_lut u_lut (
    .rate_sel_in    (b15[ctio_pkg::RATE_LSB +: 3]),
    .low_set_in     (b14[ctio_pkg::LOW_RATE_BIT]),
    .ramp_sel_in    (b15[ctio_pkg::RAMP_LSB +: 2]),
    .rate_kbps_out  (lut_rate),
    .ramp_rd_ms_out (lut_ramp_rd),
    .ramp_wr_ms_out (lut_ramp_wr)
  );

  // Active bytes change only when the loader captures them
  for (genvar g = 0; g < ctio_pkg::NUM_OPT; g++) begin : g_opt
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        opt_reg[g] <= ctio_pkg::OPT_RESET;
      end else if (ld_we && ld_idx == 2'(g)) begin
        opt_reg[g] <= nvs_rdata_in;
      end
    end
  end

  // Software writes go to the store; reload makes them active
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      nvs_wr_reg    <= 1'b0;
      nvs_waddr_reg <= 5'h00;
      nvs_wdata_reg <= 8'h00;
      early_reg     <= ctio_pkg::EARLY_RESET;
    end else begin
      nvs_wr_reg <= reg_wr_in & is_opt;
      if (reg_wr_in && is_opt) begin
        nvs_waddr_reg <= reg_addr_in;
        nvs_wdata_reg <= reg_wdata_in;
      end
      if (reg_wr_in && is_ctrl) begin
        early_reg <= reg_wdata_in[ctio_pkg::CTRL_EARLY_BIT];
      end
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= reg_rd_in ? rd_mux : 8'h00;
    end
  end

  // Bits pass straight through: one means switch on
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      buffered_host_port_out     <= 1'b0;
      buffered_configured_out    <= 1'b0;
      buffered_from_store_out    <= 1'b0;
      low_rate_set_out           <= 1'b0;
      go_sets_interface_busy_out <= 1'b0;
      parity_check_off_out       <= 1'b0;
      end_of_tape_indication_out <= 1'b0;
    end else begin
      buffered_host_port_out     <= b13[ctio_pkg::BUF_SEL_BIT];
      buffered_configured_out    <= early_reg;
      buffered_from_store_out    <= b13[ctio_pkg::BUF_FROM_NV_BIT];
      low_rate_set_out           <= b14[ctio_pkg::LOW_RATE_BIT];
      go_sets_interface_busy_out <= b14[ctio_pkg::GO_BUSY_BIT];
      parity_check_off_out       <= b14[ctio_pkg::PARITY_OFF_BIT];
      end_of_tape_indication_out <= b14[ctio_pkg::EOT_MARK_BIT];
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      write_retries_out       <= 6'h00;
      read_retries_out        <= 4'h0;
      cache_mode_out          <= 2'h0;
      cache_enabled_out       <= 1'b0;
      cache_long_block_out    <= 1'b0;
      cache_mode_reserved_out <= 1'b0;
    end else begin
      write_retries_out       <= ctio_pkg::RETRY_WR[retry_w];
      read_retries_out        <= ctio_pkg::RETRY_RD[retry_w];
      cache_mode_out          <= cache_w;
      cache_enabled_out       <= (cache_w == ctio_pkg::CACHE_NORMAL);
      cache_long_block_out    <= (cache_w == ctio_pkg::CACHE_LONG);
      cache_mode_reserved_out <= (cache_w == ctio_pkg::CACHE_RSVD);
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ramp_read_ms_out   <= 4'h0;
      ramp_write_ms_out  <= 7'h00;
      host_rate_kbps_out <= 11'h000;
      compat_code_out    <= 3'h0;
      stop_marks_out     <= 8'h00;
    end else begin
      ramp_read_ms_out   <= lut_ramp_rd;
      ramp_write_ms_out  <= lut_ramp_wr;
      host_rate_kbps_out <= lut_rate;
      compat_code_out    <= compat_w;
      stop_marks_out     <= marks_count_w;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign nvs_wr_out    = nvs_wr_reg;
  assign nvs_waddr_out = nvs_waddr_reg;
  assign nvs_wdata_out = nvs_wdata_reg;

  wire [31:0] opt_all = {b13, b14, b15, b17};

  // Also covers the load that starts by itself when reset lets go
  a_load_after_reset: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ($fell(sys_rst_in) || (ld_busy && !$past(ld_busy))) |-> ##[1:20] !ld_busy)
    else $error("option load did not finish");

  a_settings_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !ld_we |=> $stable(opt_all))
    else $error("option byte changed without a load");

  a_store_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (reg_wr_in && is_opt) |=> (nvs_wr_out && nvs_wdata_out == $past(reg_wdata_in)))
    else $error("option write not passed to store");

  a_general_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (reg_rd_in && (reg_addr_in == ctio_pkg::OFF_GENERAL_A ||
                   reg_addr_in == ctio_pkg::OFF_GENERAL_B)) |=> reg_rdata_out == 8'h00)
    else $error("general byte read not zero");

  a_cache_long: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!$past(sys_rst_in) && $past(cache_w) == 2'h3) |-> (cache_long_block_out && !cache_enabled_out))
    else $error("long block mode not decoded");

  a_marks_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!$past(sys_rst_in) && $past(marks_w) == 4'h0) |-> stop_marks_out == 8'hff)
    else $error("zero mark code not 255");

  a_ramp_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!$past(sys_rst_in) && $past(b15[4:3]) == 2'h3) |-> (ramp_write_ms_out == 7'h78 &&
                                                        ramp_read_ms_out == 4'h8))
    else $error("ramp code 3 not decoded");

  a_compat_early: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!$past(sys_rst_in) && $past(early_reg)) |-> (compat_code_out[2] == 1'b0 &&
                                                 compat_code_out[1:0] == $past(b15[6:5])))
    else $error("early compat code wrong");

  a_rate_top: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!$past(sys_rst_in) && $past(b15[2:0]) == 3'h7 && $past(b14[7])) |-> host_rate_kbps_out == 11'h0c1)
    else $error("low rate top entry wrong");

  a_rate_base: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!$past(sys_rst_in) && $past(b15[2:0]) == 3'h0 && !$past(b14[7])) |->
      host_rate_kbps_out == 11'h116)
    else $error("high rate first entry wrong");

  a_ramp_two: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!$past(sys_rst_in) && $past(b15[4:3]) == 2'h1) |-> (ramp_write_ms_out == 7'h02 &&
                                                        ramp_read_ms_out == 4'h2))
    else $error("ramp code 1 not decoded");

  a_buf_select: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !$past(sys_rst_in) |-> (buffered_host_port_out == $past(b13[6]) &&
                            buffered_from_store_out == $past(b13[4])))
    else $error("buffered interface bits not passed");

  a_cache_flags: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !$past(sys_rst_in) |-> (low_rate_set_out == $past(b14[7]) &&
                            go_sets_interface_busy_out == $past(b14[6]) &&
                            parity_check_off_out == $past(b14[5]) &&
                            end_of_tape_indication_out == $past(b14[4])))
    else $error("cache flag bits not passed");

  a_retry_top: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!$past(sys_rst_in) && $past(b14[3:2]) == 2'h3) |-> (write_retries_out == 6'h30 &&
                                                        read_retries_out == 4'hc))
    else $error("top retry budget wrong");

  a_retry_low: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!$past(sys_rst_in) && $past(b14[3:2]) == 2'h1) |-> (write_retries_out == 6'h10 &&
                                                        read_retries_out == 4'h4))
    else $error("low retry budget wrong");

  a_cache_normal: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!$past(sys_rst_in) && $past(b14[1:0]) == 2'h0) |-> (cache_enabled_out &&
                                                        !cache_long_block_out &&
                                                        !cache_mode_reserved_out))
    else $error("normal cache mode not decoded");

  a_cache_off: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!$past(sys_rst_in) && $past(b14[1:0]) == 2'h1) |-> (cache_mode_out == 2'h1 &&
                                                        !cache_enabled_out &&
                                                        !cache_long_block_out &&
                                                        !cache_mode_reserved_out))
    else $error("non-cached mode not decoded");

  a_cache_rsvd: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!$past(sys_rst_in) && $past(b14[1:0]) == 2'h2) |-> (cache_mode_reserved_out &&
                                                        !cache_enabled_out &&
                                                        !cache_long_block_out))
    else $error("reserved cache mode not flagged");

  a_compat_late: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!$past(sys_rst_in) && !$past(early_reg)) |-> compat_code_out == $past(b15[7:5]))
    else $error("later compat code wrong");

  a_marks_count: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!$past(sys_rst_in) && $past(b17[3:0]) != 4'h0) |->
      stop_marks_out == {4'h0, $past(b17[3:0])})
    else $error("mark count not passed");

  a_layout_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !$past(sys_rst_in) |-> buffered_configured_out == $past(early_reg))
    else $error("configured meaning not tracked");

endmodule

`default_nettype wire

/* File: verification/test_ctio_option_decoder.sv */
`timescale 1ns/100ps
`default_nettype none

module test_ctio_option_decoder;
  logic        clk_in;
  logic        sys_rst_in;
  logic [4:0]  reg_addr_in;
  logic [7:0]  reg_wdata_in;
  logic        reg_wr_in;
  logic        reg_rd_in;
  logic [7:0]  reg_rdata_out;
  logic [7:0]  nvs_rdata_in;
  logic        nvs_rd_out;
  logic [4:0]  nvs_raddr_out;
  logic        nvs_wr_out;
  logic [4:0]  nvs_waddr_out;
  logic [7:0]  nvs_wdata_out;
  logic        buf_sel;
  logic        buf_cfg;
  logic        buf_src;
  logic        low_rate;
  logic        go_busy;
  logic        par_off;
  logic        eot_ind;
  logic [5:0]  wr_retry;
  logic [3:0]  rd_retry;
  logic [1:0]  cmode;
  logic        c_en;
  logic        c_long;
  logic        c_rsvd;
  logic [3:0]  ramp_rd;
  logic [6:0]  ramp_wr;
  logic [10:0] rate;
  logic [2:0]  compat;
  logic [7:0]  marks;
  logic [7:0]  nvs_mem [0:31];
  logic [7:0]  v;
  logic [2:0]  kk;
  logic [1:0]  r;
  int          err_count;
  int          check_count;
  logic [10:0] lo_tab [0:7] = '{11'h00a, 11'h01e, 11'h032, 11'h048,
                                11'h064, 11'h078, 11'h09c, 11'h0c1};
  logic [10:0] hi_tab [0:7] = '{11'h116, 11'h138, 11'h165, 11'h1a0,
                                11'h1f4, 11'h271, 11'h341, 11'h4e2};
  logic [3:0]  rr_tab [0:3] = '{4'h0, 4'h2, 4'h4, 4'h8};
  logic [6:0]  rw_tab [0:3] = '{7'h00, 7'h02, 7'h04, 7'h78};

  ctio_option_decoder dut_u (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .nvs_rdata_in(nvs_rdata_in), .nvs_rd_out(nvs_rd_out), .nvs_raddr_out(nvs_raddr_out),
    .nvs_wr_out(nvs_wr_out), .nvs_waddr_out(nvs_waddr_out), .nvs_wdata_out(nvs_wdata_out),
    .buffered_host_port_out(buf_sel), .buffered_configured_out(buf_cfg),
    .buffered_from_store_out(buf_src), .low_rate_set_out(low_rate),
    .go_sets_interface_busy_out(go_busy), .parity_check_off_out(par_off),
    .end_of_tape_indication_out(eot_ind), .write_retries_out(wr_retry),
    .read_retries_out(rd_retry), .cache_mode_out(cmode), .cache_enabled_out(c_en),
    .cache_long_block_out(c_long), .cache_mode_reserved_out(c_rsvd),
    .ramp_read_ms_out(ramp_rd), .ramp_write_ms_out(ramp_wr),
    .host_rate_kbps_out(rate), .compat_code_out(compat), .stop_marks_out(marks)
  );

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Store model; between reads the data lines wander so stale data is never reused
  always @(posedge clk_in) begin
    if (nvs_wr_out) nvs_mem[nvs_waddr_out] <= nvs_wdata_out;
    if (nvs_rd_out) nvs_rdata_in <= nvs_mem[nvs_raddr_out];
    else nvs_rdata_in <= ~nvs_rdata_in;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
    @(posedge clk_in);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  // Polls the busy flag rather than trusting a fixed load time
  task automatic wait_load(input logic early);
    repeat (3) @(posedge clk_in);
    v = 8'h04;
    for (int n = 0; n < 40 && v[2] !== 1'b0; n++) rd(5'h00, v);
    chk(v, {6'h00, early, 1'b0});
    repeat (3) @(posedge clk_in);
  endtask

  task automatic reload(input logic early);
    wr(5'h00, {6'h00, early, 1'b1});
    wait_load(early);
  endtask

  task automatic stop_test;
    if (err_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #200000;
    err_count++;
    stop_test();
  end

  initial begin
    err_count = 0;
    check_count = 0;
    sys_rst_in = 1'b1;
    reg_addr_in = 5'h00;
    reg_wdata_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    nvs_rdata_in = 8'h00;
    for (int i = 0; i < 32; i++) nvs_mem[i] = 8'h00;
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    wait_load(1'b0);
    chk(marks, 8'hff);
    chk({c_en, c_long, c_rsvd, cmode}, 5'h10);
    chk(rate, 11'h116);
    wr(5'h0e, 8'h03);
    rd_chk(5'h0e, 8'h00);
    chk(cmode, 2'h0);
    wr(5'h10, 8'h5a);
    wr(5'h12, 8'ha5);
    for (int k = 0; k < 8; k++) begin
      kk = k[2:0];
      r = kk[1:0];
      wr(5'h0d, {kk[2], kk[0], 1'b1, kk[1], 4'ha});
      wr(5'h0e, {kk[0], kk[1], kk[2], ~kk[0], kk[1:0], kk[2:1]});
      wr(5'h0f, {kk, kk[1:0], kk});
      wr(5'h11, {4'h5, 1'b1, kk});
      reload(1'b0);
      rd_chk(5'h0d, {kk[2], kk[0], 1'b1, kk[1], 4'ha});
      rd_chk(5'h0e, {kk[0], kk[1], kk[2], ~kk[0], kk[1:0], kk[2:1]});
      rd_chk(5'h0f, {kk, kk[1:0], kk});
      rd_chk(5'h11, {4'h5, 1'b1, kk});
      rd_chk(5'h10, 8'h00);
      rd_chk(5'h12, 8'h00);
      rd_chk(5'h1f, 8'h00);
      chk({buf_sel, buf_src, buf_cfg}, {kk[0], kk[1], 1'b0});
      chk({low_rate, go_busy, par_off, eot_ind}, {kk[0], kk[1], kk[2], ~kk[0]});
      chk(wr_retry, {r, 4'h0});
      chk(rd_retry, (r < 2'h2) ? 4'h4 : {r, 2'h0});
      chk({c_en, c_long, c_rsvd, cmode},
          {kk[2:1] == 2'h0, kk[2:1] == 2'h3, kk[2:1] == 2'h2, kk[2:1]});
      chk({ramp_rd, ramp_wr}, {rr_tab[r], rw_tab[r]});
      chk(rate, kk[0] ? lo_tab[kk] : hi_tab[kk]);
      chk(compat, kk);
      chk(marks, {5'h01, kk});
    end
    // Same top bits under both layouts, so only the layout flag can explain a change
    wr(5'h0f, 8'he0);
    reload(1'b1);
    chk({compat, buf_cfg}, {3'h3, 1'b1});
    reload(1'b0);
    chk({compat, buf_cfg}, {3'h7, 1'b0});
    stop_test();
  end
endmodule

`default_nettype wire
